// *** rtl/pdcr_chan.sv ***
// one direction of the channel: pointers, counters and bus request
// assumes the bus matrix holds grant high for exactly one done pulse
`timescale 1ns/1ps
`default_nettype none
`include "pdcr_params.svh"
module pdcr_chan
  import pdcr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        enable,
  input  wire logic        ready,
  input  wire logic [1:0]  unit,
  input  wire logic        wr_ptr,
  input  wire logic        wr_cnt,
  input  wire logic        wr_nptr,
  input  wire logic        wr_ncnt,
  input  wire logic [31:0] wdata,
  input  wire logic        done,
  output var  logic        req,
  output var  pdcr_chan_t  chan,
  output var  logic        end_pulse,
  output var  logic        last_pulse
);
  typedef struct packed {
    pdcr_chan_t c;
    pdcr_xfer_t st;
    logic       endp;
    logic       lastp;
  } pdcr_cst_t;

  pdcr_cst_t s_reg;
  pdcr_cst_t s_next;
  logic [31:0] step;

  always_comb
  begin
    case (unit)
      2'h0:    step = 32'h0000_0001;
      2'h1:    step = 32'h0000_0002;
      default: step = 32'h0000_0004;
    endcase
    s_next = s_reg;
    s_next.endp = 1'b0;
    s_next.lastp = 1'b0;
    case (s_reg.st)
      PDCR_IDLE:
        if (enable && ready && s_reg.c.count != `PDCR_CNT_RST)
          s_next.st = PDCR_REQ;
      PDCR_REQ:
        if (done)
        begin
          s_next.st = PDCR_IDLE;
          s_next.c.addr = s_reg.c.addr + step;
          s_next.c.count = s_reg.c.count - 16'h0001;
          if (s_reg.c.count == 16'h0001)
          begin
            s_next.endp = 1'b1;
            if (s_reg.c.nxt_count != `PDCR_CNT_RST)
            begin
              s_next.c.addr = s_reg.c.nxt_addr;
              s_next.c.count = s_reg.c.nxt_count;
              s_next.c.nxt_addr = `PDCR_PTR_RST;
              s_next.c.nxt_count = `PDCR_CNT_RST;
            end
            else
              s_next.lastp = 1'b1;
          end
        end
        else if (!enable)
          s_next.st = PDCR_IDLE;
      default: s_next.st = PDCR_IDLE;
    endcase
    // software writes override the engine in the same cycle
    if (wr_ptr)
      s_next.c.addr = wdata;
    if (wr_cnt)
      s_next.c.count = wdata[15:0];
    if (wr_nptr)
      s_next.c.nxt_addr = wdata;
    if (wr_ncnt)
      s_next.c.nxt_count = wdata[15:0];
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg.c.addr      <= `PDCR_PTR_RST;
      s_reg.c.count     <= `PDCR_CNT_RST;
      s_reg.c.nxt_addr  <= `PDCR_PTR_RST;
      s_reg.c.nxt_count <= `PDCR_CNT_RST;
      s_reg.st          <= PDCR_IDLE;
      s_reg.endp        <= 1'b0;
      s_reg.lastp       <= 1'b0;
    end
    else
      s_reg <= s_next;
  end

  assign req = (s_reg.st == PDCR_REQ);
  assign chan = s_reg.c;
  assign end_pulse = s_reg.endp;
  assign last_pulse = s_reg.lastp;
endmodule : pdcr_chan
`default_nettype wire

// *** rtl/pdcr_params.svh ***
// register offsets, field positions, reset values and widths
// of the peripheral dma channel register block
`ifndef PDCR_PARAMS_SVH
`define PDCR_PARAMS_SVH

`define PDCR_OFF_RX_PTR    12'h100
`define PDCR_OFF_RX_CNT    12'h104
`define PDCR_OFF_TX_PTR    12'h108
`define PDCR_OFF_TX_CNT    12'h10C
`define PDCR_OFF_RXN_PTR   12'h110
`define PDCR_OFF_RXN_CNT   12'h114
`define PDCR_OFF_TXN_PTR   12'h118
`define PDCR_OFF_TXN_CNT   12'h11C
`define PDCR_OFF_CTRL      12'h120
`define PDCR_OFF_STAT      12'h124
`define PDCR_OFF_MODE      12'h128
`define PDCR_OFF_FLAGS     12'h12C

`define PDCR_BIT_RX_ON     0
`define PDCR_BIT_RX_OFF    1
`define PDCR_BIT_TX_ON     8
`define PDCR_BIT_TX_OFF    9

`define PDCR_BIT_HALF      0
`define PDCR_BIT_SIZE_LO   1
`define PDCR_BIT_SIZE_HI   2

`define PDCR_BIT_RX_END    0
`define PDCR_BIT_RX_FULL   1
`define PDCR_BIT_TX_END    2
`define PDCR_BIT_TX_EMPTY  3

`define PDCR_CNT_W         16
`define PDCR_PTR_RST       32'h0000_0000
`define PDCR_CNT_RST       16'h0000

`endif

// *** rtl/pdcr_pkg.sv ***
// types shared by the peripheral dma channel register block
// assumes the params header is on the include path
package pdcr_pkg;
  typedef enum logic [1:0] {
    PDCR_UNIT_BYTE,
    PDCR_UNIT_HALF,
    PDCR_UNIT_WORD,
    PDCR_UNIT_RSVD
  } pdcr_unit_t;

  typedef enum {
    PDCR_IDLE,
    PDCR_REQ
  } pdcr_xfer_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] count;
    logic [31:0] nxt_addr;
    logic [15:0] nxt_count;
  } pdcr_chan_t;
endpackage : pdcr_pkg

// *** rtl/pdcr_top.sv ***
// peripheral dma channel registers with apb slave and two engines
// assumes synchronous peripheral ready inputs and a bus matrix grant
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pdcr_params.svh"
module pdcr_top
  import pdcr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_ready,
  input  wire logic        tx_ready,
  input  wire logic        rx_done,
  input  wire logic        tx_done,
  output logic             rx_req,
  output logic             tx_req,
  output logic      [31:0] rx_addr,
  output logic      [31:0] tx_addr,
  output logic             rx_end_flag,
  output logic             rx_buffers_full_flag,
  output logic             tx_end_flag,
  output logic             tx_buffers_empty_flag
);
  typedef struct packed {
    logic        rx_on;
    logic        tx_on;
    logic        half;
    logic [1:0]  unit;
    logic [3:0]  flags;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
    logic        rxr;
    logic        txr;
    logic [31:0] rxa;
    logic [31:0] txa;
  } pdcr_top_t;

  pdcr_top_t s_reg;
  pdcr_top_t s_next;

  logic       acc;
  logic       wr;
  logic       hit;
  logic       w_rp;
  logic       w_rc;
  logic       w_tp;
  logic       w_tc;
  logic       w_rnp;
  logic       w_rnc;
  logic       w_tnp;
  logic       w_tnc;
  logic       rx_q;
  logic       tx_q;
  logic       rx_e;
  logic       rx_l;
  logic       tx_e;
  logic       tx_l;
  logic       tx_en_eff;
  logic       tx_rdy_eff;
  logic       tx_done_eff;
  pdcr_chan_t rxc;
  pdcr_chan_t txc;

  // write strobes fire on the first access phase cycle, the cycle before pready is high
  assign acc = psel && penable && !s_reg.rdy;
  assign wr  = acc && pwrite;

  // in half duplex the transmit engine owns the single shared
  // register set, so receive-side writes are steered onto it
  assign w_rp  = wr && paddr == `PDCR_OFF_RX_PTR && !s_reg.half;
  assign w_rc  = wr && paddr == `PDCR_OFF_RX_CNT && !s_reg.half;
  assign w_rnp = wr && paddr == `PDCR_OFF_RXN_PTR && !s_reg.half;
  assign w_rnc = wr && paddr == `PDCR_OFF_RXN_CNT && !s_reg.half;
  assign w_tp  = wr && (paddr == `PDCR_OFF_TX_PTR ||
                 (s_reg.half && paddr == `PDCR_OFF_RX_PTR));
  assign w_tc  = wr && (paddr == `PDCR_OFF_TX_CNT ||
                 (s_reg.half && paddr == `PDCR_OFF_RX_CNT));
  assign w_tnp = wr && (paddr == `PDCR_OFF_TXN_PTR ||
                 (s_reg.half && paddr == `PDCR_OFF_RXN_PTR));
  assign w_tnc = wr && (paddr == `PDCR_OFF_TXN_CNT ||
                 (s_reg.half && paddr == `PDCR_OFF_RXN_CNT));

  // half duplex: one engine moves data in whichever direction is on
  assign tx_en_eff   = s_reg.half ? (s_reg.rx_on || s_reg.tx_on)
                                  : s_reg.tx_on;
  assign tx_rdy_eff  = s_reg.half ? (s_reg.rx_on ? rx_ready : tx_ready)
                                  : tx_ready;
  assign tx_done_eff = s_reg.half ? (s_reg.rx_on ? rx_done : tx_done)
                                  : tx_done;

  pdcr_chan u_rx (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .enable     (s_reg.rx_on && !s_reg.half),
    .ready      (rx_ready),
    .unit       (s_reg.unit),
    .wr_ptr     (w_rp),
    .wr_cnt     (w_rc),
    .wr_nptr    (w_rnp),
    .wr_ncnt    (w_rnc),
    .wdata      (pwdata),
    .done       (rx_done),
    .req        (rx_q),
    .chan       (rxc),
    .end_pulse  (rx_e),
    .last_pulse (rx_l)
  );

  pdcr_chan u_tx (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .enable     (tx_en_eff),
    .ready      (tx_rdy_eff),
    .unit       (s_reg.unit),
    .wr_ptr     (w_tp),
    .wr_cnt     (w_tc),
    .wr_nptr    (w_tnp),
    .wr_ncnt    (w_tnc),
    .wdata      (pwdata),
    .done       (tx_done_eff),
    .req        (tx_q),
    .chan       (txc),
    .end_pulse  (tx_e),
    .last_pulse (tx_l)
  );

  always_comb
  begin
    s_next = s_reg;
    s_next.rdy = acc;
    s_next.err = 1'b0;
    hit = 1'b1;
    s_next.rdata = 32'h0000_0000;
    if (acc)
    begin
      case (paddr)
        `PDCR_OFF_RX_PTR:  s_next.rdata = s_reg.half ? txc.addr : rxc.addr;
        `PDCR_OFF_TX_PTR:  s_next.rdata = txc.addr;
        `PDCR_OFF_RX_CNT:
          s_next.rdata = {16'h0000, s_reg.half ? txc.count : rxc.count};
        `PDCR_OFF_TX_CNT:  s_next.rdata = {16'h0000, txc.count};
        `PDCR_OFF_RXN_PTR:
          s_next.rdata = s_reg.half ? txc.nxt_addr : rxc.nxt_addr;
        `PDCR_OFF_TXN_PTR: s_next.rdata = txc.nxt_addr;
        `PDCR_OFF_RXN_CNT:
          s_next.rdata = {16'h0000,
                          s_reg.half ? txc.nxt_count : rxc.nxt_count};
        `PDCR_OFF_TXN_CNT: s_next.rdata = {16'h0000, txc.nxt_count};
        `PDCR_OFF_CTRL:    s_next.rdata = 32'h0000_0000;
        `PDCR_OFF_STAT:
        begin
          s_next.rdata[`PDCR_BIT_RX_ON] = s_reg.rx_on;
          s_next.rdata[`PDCR_BIT_TX_ON] = s_reg.tx_on;
        end
        `PDCR_OFF_MODE:
          s_next.rdata = {29'h0000_0000, s_reg.unit, s_reg.half};
        `PDCR_OFF_FLAGS:   s_next.rdata = {28'h000_0000, s_reg.flags};
        default:           hit = 1'b0;
      endcase
      s_next.err = !hit;
      if (pwrite)
        s_next.rdata = 32'h0000_0000;
    end
    if (wr && paddr == `PDCR_OFF_CTRL)
    begin
      if (pwdata[`PDCR_BIT_TX_ON] && !(s_reg.half && s_reg.rx_on))
        s_next.tx_on = 1'b1;
      if (pwdata[`PDCR_BIT_RX_ON] && !pwdata[`PDCR_BIT_RX_OFF])
      begin
        s_next.rx_on = 1'b1;
        if (s_reg.half)
          s_next.tx_on = 1'b0;
      end
      if (pwdata[`PDCR_BIT_RX_OFF])
      begin
        s_next.rx_on = 1'b0;
        if (s_reg.half)
          s_next.tx_on = 1'b0;
      end
      if (pwdata[`PDCR_BIT_TX_OFF])
      begin
        s_next.tx_on = 1'b0;
        if (s_reg.half)
          s_next.rx_on = 1'b0;
      end
    end
    // mode only changes while both directions are idle
    if (wr && paddr == `PDCR_OFF_MODE && !s_reg.rx_on && !s_reg.tx_on)
    begin
      s_next.half = pwdata[`PDCR_BIT_HALF];
      s_next.unit = pwdata[`PDCR_BIT_SIZE_HI:`PDCR_BIT_SIZE_LO];
    end
    // nonzero count writes clear flags; a same-cycle set still wins
    if ((w_rc && pwdata[15:0] != 16'h0000) ||
        (w_rnc && pwdata[15:0] != 16'h0000))
    begin
      s_next.flags[`PDCR_BIT_RX_END] = 1'b0;
      s_next.flags[`PDCR_BIT_RX_FULL] = 1'b0;
    end
    if ((w_tc && pwdata[15:0] != 16'h0000) ||
        (w_tnc && pwdata[15:0] != 16'h0000))
    begin
      s_next.flags[`PDCR_BIT_TX_END] = 1'b0;
      s_next.flags[`PDCR_BIT_TX_EMPTY] = 1'b0;
    end
    if (rx_e)
      s_next.flags[`PDCR_BIT_RX_END] = 1'b1;
    if (rx_l)
      s_next.flags[`PDCR_BIT_RX_FULL] = 1'b1;
    if (tx_e)
      s_next.flags[`PDCR_BIT_TX_END] = 1'b1;
    if (tx_l)
      s_next.flags[`PDCR_BIT_TX_EMPTY] = 1'b1;
    s_next.rxr = rx_q || (s_reg.half && s_reg.rx_on && tx_q);
    s_next.txr = tx_q && !(s_reg.half && s_reg.rx_on);
    s_next.rxa = s_reg.half ? txc.addr : rxc.addr;
    s_next.txa = txc.addr;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg.rx_on <= 1'b0;
      s_reg.tx_on <= 1'b0;
      s_reg.half  <= 1'b0;
      s_reg.unit  <= 2'h0;
      s_reg.flags <= 4'h0;
      s_reg.rdata <= 32'h0000_0000;
      s_reg.rdy   <= 1'b0;
      s_reg.err   <= 1'b0;
      s_reg.rxr   <= 1'b0;
      s_reg.txr   <= 1'b0;
      s_reg.rxa   <= `PDCR_PTR_RST;
      s_reg.txa   <= `PDCR_PTR_RST;
    end
    else
      s_reg <= s_next;
  end

  assign prdata  = s_reg.rdata;
  assign pready  = s_reg.rdy;
  assign pslverr = s_reg.err;
  assign rx_req  = s_reg.rxr;
  assign tx_req  = s_reg.txr;
  assign rx_addr = s_reg.rxa;
  assign tx_addr = s_reg.txa;
  assign rx_end_flag           = s_reg.flags[`PDCR_BIT_RX_END];
  assign rx_buffers_full_flag  = s_reg.flags[`PDCR_BIT_RX_FULL];
  assign tx_end_flag           = s_reg.flags[`PDCR_BIT_TX_END];
  assign tx_buffers_empty_flag = s_reg.flags[`PDCR_BIT_TX_EMPTY];
endmodule : pdcr_top
`default_nettype wire

// *** verification/pdcr_far.sv ***
// far side model: serial peripheral ready plus bus matrix grant
// assumes the channel holds req until the done pulse it gets
`timescale 1ns/1ps
`default_nettype none
module pdcr_far #(
  parameter int LAT = 1
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic go,
  input  wire logic req,
  output var  logic ready,
  output var  logic done
);
  logic [7:0] wait_reg;
  logic       hold_reg;
  assign ready = go;
  // hold stops a second done while req is still falling
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_reg <= 8'h00;
      hold_reg <= 1'b0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!req)
      begin
        wait_reg <= 8'h00;
        hold_reg <= 1'b0;
      end
      else if (!hold_reg && wait_reg == 8'(LAT))
      begin
        done     <= 1'b1;
        hold_reg <= 1'b1;
      end
      else if (!hold_reg)
        wait_reg <= wait_reg + 8'h01;
    end
  end
endmodule : pdcr_far
`default_nettype wire

// *** verification/pdcr_top_bench.sv ***
// self-checking bench for the channel register block over apb
// assumes the far side models answer every channel request
`timescale 1ns/1ps
`default_nettype none
`include "pdcr_params.svh"
module pdcr_top_bench;
  logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rx_addr, tx_addr, v;
  logic        rx_ready, tx_ready, rx_done, tx_done, rx_req, tx_req, err;
  logic        rx_end_flag, rx_buffers_full_flag;
  logic        rx_go = 1'b1;
  logic        tx_go = 1'b1;
  logic        tx_end_flag, tx_buffers_empty_flag;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [11:0] cw [12] = '{12'h003, 12'h100, 12'h000, 12'h001, 12'h200,
    12'h002, 12'h001, 12'h100, 12'h002, 12'h100, 12'h001, 12'h200};
  logic [11:0] sw [12] = '{12'h000, 12'h100, 12'h100, 12'h101, 12'h001,
    12'h000, 12'h001, 12'h001, 12'h000, 12'h100, 12'h001, 12'h000};
  pdcr_top u_dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_ready, .tx_ready, .rx_done,
    .tx_done, .rx_req, .tx_req, .rx_addr, .tx_addr, .rx_end_flag,
    .rx_buffers_full_flag, .tx_end_flag, .tx_buffers_empty_flag);
  // prompt receiver and slow transmitter
  pdcr_far #(.LAT(0)) u_rx_far (.sys_clk, .arst_n, .go(rx_go),
    .req(rx_req), .ready(rx_ready), .done(rx_done));
  pdcr_far #(.LAT(3)) u_tx_far (.sys_clk, .arst_n, .go(tx_go),
    .req(tx_req), .ready(tx_ready), .done(tx_done));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      bad_count++;
      $display("ERROR %0t run timed out", $time);
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask : rdc
  // waits for the last buffer to drain, rx too when both is set
  task automatic wait_flags(input logic both);
    int n;
    n = 0;
    while (!(tx_buffers_empty_flag === 1'b1
             && (rx_buffers_full_flag === 1'b1 || !both)) && n < 300)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n < 300), 32'h0000_0001);
  endtask : wait_flags
  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 12; i++)
      rdc(12'h100 + 12'(4 * i), 32'h0000_0000);
    rdc(12'h130, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    for (int i = 0; i < 8; i++)
    begin
      v = {16'hA5C3, 16'(i + 1)};
      wr(12'h100 + 12'(4 * i), v);
      rdc(12'h100 + 12'(4 * i), i[0] ? {16'h0000, v[15:0]} : v);
      wr(12'h100 + 12'(4 * i), 32'h0000_0000);
    end
    wr(`PDCR_OFF_TX_PTR, 32'h0000_1000);
    wr(`PDCR_OFF_TX_CNT, 32'h0000_0002);
    wr(`PDCR_OFF_TXN_PTR, 32'h0000_2000);
    wr(`PDCR_OFF_TXN_CNT, 32'h0000_0001);
    // peripheral not ready yet: enabled channel must stay quiet
    tx_go <= 1'b0;
    wr(`PDCR_OFF_CTRL, 32'h0000_0100);
    repeat (4) @(posedge sys_clk);
    chk(32'(tx_req), 32'h0000_0000);
    rdc(`PDCR_OFF_TX_CNT, 32'h0000_0002);
    tx_go <= 1'b1;
    wait_flags(1'b0);
    chk(tx_addr, 32'h0000_2001);
    chk(32'(tx_end_flag), 32'h0000_0001);
    rdc(`PDCR_OFF_TX_CNT, 32'h0000_0000);
    rdc(`PDCR_OFF_TXN_CNT, 32'h0000_0000);
    rdc(`PDCR_OFF_FLAGS, 32'h0000_000C);
    for (int u = 0; u < 4; u++)
    begin
      rx_go <= 1'b0;
      wr(`PDCR_OFF_CTRL, 32'h0000_0202);
      wr(`PDCR_OFF_MODE, 32'(u) << 1);
      wr(`PDCR_OFF_RX_PTR, 32'h0000_5000);
      wr(`PDCR_OFF_RX_CNT, 32'h0000_0001);
      wr(`PDCR_OFF_TX_PTR, 32'h0000_3000);
      wr(`PDCR_OFF_TX_CNT, 32'h0000_0001);
      wr(`PDCR_OFF_CTRL, 32'h0000_0101);
      repeat (4) @(posedge sys_clk);
      chk(32'(rx_req), 32'h0000_0000);
      rx_go <= 1'b1;
      wait_flags(1'b1);
      chk({30'h0, rx_end_flag, tx_end_flag}, 32'h0000_0003);
      // unit code 3 steps like a word
      chk(rx_addr, 32'h0000_5000 + (u == 3 ? 32'h4 : 32'h1 << u));
      chk(tx_addr, 32'h0000_3000 + (u == 3 ? 32'h4 : 32'h1 << u));
    end
    wr(`PDCR_OFF_CTRL, 32'h0000_0202);
    // second half runs half duplex and never sets both enables
    for (int i = 0; i < 12; i++)
    begin
      if (i == 6)
        wr(`PDCR_OFF_MODE, 32'h0000_0001);
      wr(`PDCR_OFF_CTRL, 32'(cw[i]));
      rdc(`PDCR_OFF_STAT, 32'(sw[i]));
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(12'h108 + 12'(4 * (k % 2) + 16 * (k / 2)), 32'h0000_4000 + k);
      rdc(12'h100 + 12'(4 * (k % 2) + 16 * (k / 2)), 32'h0000_4000 + k);
    end
    // half duplex transmit through the receive view of the counts
    wr(`PDCR_OFF_RXN_CNT, 32'h0000_0000);
    wr(`PDCR_OFF_RX_CNT, 32'h0000_0001);
    wr(`PDCR_OFF_CTRL, 32'h0000_0100);
    wait_flags(1'b0);
    chk(tx_addr, 32'h0000_4001);
    rdc(`PDCR_OFF_RX_PTR, 32'h0000_4001);
    rdc(`PDCR_OFF_RX_CNT, 32'h0000_0000);
    results();
  end
endmodule : pdcr_top_bench
bind pdcr_top pdcr_top_sva u_sva (.sys_clk, .arst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_ready,
  .tx_ready, .rx_done, .tx_done, .rx_req, .tx_req, .rx_addr, .tx_addr,
  .rx_end_flag, .rx_buffers_full_flag, .tx_end_flag,
  .tx_buffers_empty_flag);
`default_nettype wire

// *** verification/pdcr_top_sva.sv ***
// checker for the channel register block, top ports only
// assumes the apb master holds paddr and pwrite until pready
`timescale 1ns/1ps
`default_nettype none
`include "pdcr_params.svh"
module pdcr_top_sva (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_ready,
  input wire logic        tx_ready,
  input wire logic        rx_done,
  input wire logic        tx_done,
  input wire logic        rx_req,
  input wire logic        tx_req,
  input wire logic [31:0] rx_addr,
  input wire logic [31:0] tx_addr,
  input wire logic        rx_end_flag,
  input wire logic        rx_buffers_full_flag,
  input wire logic        tx_end_flag,
  input wire logic        tx_buffers_empty_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic rd_ok;
  logic cnt_rd;
  assign rd_ok = psel && penable && pready && !pwrite;
  // counts sit on odd words between the rx count and the tx next count
  assign cnt_rd = rd_ok && paddr[2] && paddr >= `PDCR_OFF_RX_CNT
                  && paddr <= `PDCR_OFF_TXN_CNT;
  a_tx_req_cause:
    assert property ($rose(tx_req) |-> $past(tx_ready, 2))
    else $error("tx request rose without ready");
  a_rx_req_cause:
    assert property ($rose(rx_req) |-> $past(rx_ready, 2))
    else $error("rx request rose without ready");
  a_tx_req_drop:
    assert property (tx_req && tx_done |-> ##[1:2] !tx_req)
    else $error("tx request held after done");
  a_ctrl_reads_zero:
    assert property (rd_ok && paddr == `PDCR_OFF_CTRL
                     |-> prdata == 32'h0000_0000)
    else $error("control register read not zero");
  a_stat_reserved:
    assert property (rd_ok && paddr == `PDCR_OFF_STAT
                     |-> (prdata & 32'hFFFF_FEFE) == 32'h0000_0000)
    else $error("status reserved bits set");
  a_cnt_upper_zero:
    assert property (cnt_rd |-> prdata[31:16] == 16'h0000)
    else $error("count upper bits set");
  a_tx_end_cause:
    assert property ($rose(tx_end_flag) |-> $past(tx_done)
                     || $past(tx_done, 2) || $past(tx_done, 3))
    else $error("tx end flag without a unit");
  a_empty_has_end:
    assert property (tx_buffers_empty_flag |-> tx_end_flag)
    else $error("tx empty without tx end");
  a_full_has_end:
    assert property (rx_buffers_full_flag |-> rx_end_flag)
    else $error("rx full without rx end");
  c_tx_unit: cover property (tx_req && tx_done);
  c_rx_unit: cover property (rx_req && rx_done);
  c_bad_addr: cover property (pready && pslverr);
  c_rx_full: cover property ($rose(rx_buffers_full_flag));
endmodule : pdcr_top_sva
`default_nettype wire
